/* common/bsi_pkg.sv */
package bsi_pkg;
    // ==========================================================
    // register indices (byte address is four times the index)
    localparam logic [11:0] BSI_IDX_COMMAND   = 12'h004;
    localparam logic [11:0] BSI_IDX_STATUS    = 12'h006;
    localparam logic [11:0] BSI_IDX_REVISION  = 12'h008;
    localparam logic [11:0] BSI_IDX_CLASS     = 12'h009;
    localparam logic [11:0] BSI_IDX_CACHELINE = 12'h00c;
    localparam logic [11:0] BSI_IDX_LOCKCTL   = 12'h040;

    // ==========================================================
    // field positions
    localparam int BSI_CMD_PERR_BIT  = 6;
    localparam int BSI_CMD_ERR_BIT   = 8;
    localparam int BSI_ST_INTX_BIT   = 3;
    localparam int BSI_ST_CAP_BIT    = 4;
    localparam int BSI_ST_TABORT_BIT = 11;
    localparam int BSI_ST_SYSERR_BIT = 14;
    localparam int BSI_ST_POISON_BIT = 15;
    localparam int BSI_LOCK_UNLK_BIT = 0;

    // ==========================================================
    // constant values and reset values
    localparam logic [7:0]  BSI_BASE_CLASS   = 8'h06;
    localparam logic [7:0]  BSI_SUB_CLASS    = 8'h04;
    localparam logic [7:0]  BSI_PROG_IF      = 8'h00;
    localparam logic [7:0]  BSI_REV_RESET    = 8'h01;  // arbitrary value
    localparam logic [7:0]  BSI_LINE_RESET   = 8'h00;
    localparam logic [15:0] BSI_ST_FIXED_MASK = 16'h3fe7; // bits that never read one except cap
    localparam logic [1:0]  BSI_RESP_OKAY    = 2'b00;
    localparam logic [1:0]  BSI_RESP_SLVERR  = 2'b10;
endpackage

/* verilog/bsi_regs.sv */
`timescale 1ns/1ps
// Functional notes
// RULE1 - downstream port: intx flag follows hot-plug interrupt
// RULE2 - upstream port: intx flag always reads zero
// RULE3 - forwarded legacy interrupts never touch intx flag
// RULE4 - capability list bit fixed at one
// RULE5 - error message with enable sets flag; w1c
// RULE6 - poisoned primary TLP sets flag; w1c
// RULE7 - target abort sent bit always zero
// RULE8 - read-only class code 06/04/00
// RULE9 - cache line size: plain 8-bit RW, reset zero
// RULE10 - revision writable only while unlocked
// RULE11 - error enable gates reporting and forwarding
// RULE12 - reserved and unused status bits read zero
module bsi_regs
    import bsi_pkg::*;
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_n,
    input  wire logic        i_s_axi_awvalid,
    output logic             o_s_axi_awready,
    input  wire logic [31:0] i_s_axi_awaddr,
    input  wire logic        i_s_axi_wvalid,
    output logic             o_s_axi_wready,
    input  wire logic [31:0] i_s_axi_wdata,
    input  wire logic [3:0]  i_s_axi_wstrb,
    output logic             o_s_axi_bvalid,
    input  wire logic        i_s_axi_bready,
    output logic [1:0]       o_s_axi_bresp,
    input  wire logic        i_s_axi_arvalid,
    output logic             o_s_axi_arready,
    input  wire logic [31:0] i_s_axi_araddr,
    output logic             o_s_axi_rvalid,
    input  wire logic        i_s_axi_rready,
    output logic [31:0]      o_s_axi_rdata,
    output logic [1:0]       o_s_axi_rresp,
    input  wire logic        i_is_upstream,
    input  wire logic        i_hotplug_irq,
    input  wire logic        i_intx_fwd,
    input  wire logic        i_err_msg_sent,
    input  wire logic        i_poisoned_rx,
    output logic             o_err_report_en,
    output logic             o_parity_response_en
);

    // ==========================================================
    // state
    typedef struct packed {
        logic [31:0] wr_addr;
        logic        aw_got;
        logic [31:0] wr_data;
        logic [3:0]  wr_strb;
        logic        w_got;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        intx_pending_flag;
        logic        system_error_signalled;
        logic        poisoned_rx_flag;
        logic        error_report_enable;
        logic        parity_response_enable;
        logic [7:0]  revision_number;
        logic        rev_unlock;
        logic [7:0]  cache_line_bytes;
    } bsi_state_s;

    bsi_state_s cur;
    bsi_state_s next_cur;
    logic       wr_commit;
    logic [11:0] wr_idx;
    logic       wr_ok;
    logic [11:0] rd_idx;
    logic       rd_ok;

    // ==========================================================
    // address decode: upper bits must be zero for okay, low two bits ignored; writes other than status still apply by index
    assign wr_idx    = cur.wr_addr[13:2];
    assign wr_ok     = (cur.wr_addr[31:14] == 18'h0_0000);
    assign rd_idx    = i_s_axi_araddr[13:2];
    assign rd_ok     = (i_s_axi_araddr[31:14] == 18'h0_0000);
    assign wr_commit = cur.aw_got && cur.w_got && !cur.bvalid;

    // read word builder; unmapped gives zero with the hit flag in bit 32 cleared
    function automatic logic [32:0] read_word(input logic [11:0] idx, input bsi_state_s s);
        logic [32:0] r;
        r = {1'b1, 32'h0000_0000};
        case (idx)
            BSI_IDX_COMMAND: begin
                r[BSI_CMD_PERR_BIT] = s.parity_response_enable;
                r[BSI_CMD_ERR_BIT]  = s.error_report_enable;
            end
            BSI_IDX_STATUS: begin
                r[BSI_ST_INTX_BIT]   = s.intx_pending_flag;
                r[BSI_ST_CAP_BIT]    = 1'b1;   // RULE4
                r[BSI_ST_TABORT_BIT] = 1'b0;   // RULE7
                r[BSI_ST_SYSERR_BIT] = s.system_error_signalled;
                r[BSI_ST_POISON_BIT] = s.poisoned_rx_flag;
            end
            BSI_IDX_REVISION:  r[7:0]  = s.revision_number;
            BSI_IDX_CLASS:     r[23:0] = {BSI_BASE_CLASS, BSI_SUB_CLASS, BSI_PROG_IF}; // RULE8
            BSI_IDX_CACHELINE: r[7:0]  = s.cache_line_bytes;
            BSI_IDX_LOCKCTL:   r[BSI_LOCK_UNLK_BIT] = s.rev_unlock;
            default:           r[32] = 1'b0;
        endcase
        return r;
    endfunction

    // ==========================================================
    // next-state logic
    always_comb begin
        logic [32:0] rw;
        logic        hit;
        rw = read_word(rd_idx, cur);
        hit = 1'b0;
        next_cur = cur;

        // write address and data may arrive in either order
        if (i_s_axi_awvalid && o_s_axi_awready) begin
            next_cur.wr_addr = i_s_axi_awaddr;
            next_cur.aw_got  = 1'b1;
        end
        if (i_s_axi_wvalid && o_s_axi_wready) begin
            next_cur.wr_data = i_s_axi_wdata;
            next_cur.wr_strb = i_s_axi_wstrb;
            next_cur.w_got   = 1'b1;
        end
        if (cur.bvalid && i_s_axi_bready) begin
            next_cur.bvalid = 1'b0;
        end

        // interrupt status mirrors the hot-plug level, downstream only
        next_cur.intx_pending_flag = i_hotplug_irq && !i_is_upstream; // RULE1 RULE2 RULE3

        // write-one clears first; hardware sets below, so a same-cycle set wins
        if (wr_commit && wr_ok && (wr_idx == BSI_IDX_STATUS) && cur.wr_strb[1]) begin
            if (cur.wr_data[BSI_ST_SYSERR_BIT]) begin
                next_cur.system_error_signalled = 1'b0; // RULE5
            end
            if (cur.wr_data[BSI_ST_POISON_BIT]) begin
                next_cur.poisoned_rx_flag = 1'b0; // RULE6
            end
        end
        if (i_err_msg_sent && cur.error_report_enable) begin
            next_cur.system_error_signalled = 1'b1; // RULE5 RULE11
        end
        if (i_poisoned_rx) begin
            next_cur.poisoned_rx_flag = 1'b1; // RULE6
        end

        // commit a complete write, then answer on the b channel
        if (wr_commit) begin
            next_cur.aw_got = 1'b0;
            next_cur.w_got  = 1'b0;
            next_cur.bvalid = 1'b1;
            next_cur.bresp  = BSI_RESP_OKAY;
            case (wr_idx)
                BSI_IDX_COMMAND: begin
                    hit = 1'b1;
                    if (cur.wr_strb[0]) begin
                        next_cur.parity_response_enable = cur.wr_data[BSI_CMD_PERR_BIT];
                    end
                    if (cur.wr_strb[1]) begin
                        next_cur.error_report_enable = cur.wr_data[BSI_CMD_ERR_BIT]; // RULE11
                    end
                end
                BSI_IDX_STATUS:    hit = 1'b1;   // RULE12
                BSI_IDX_CLASS:     hit = 1'b1;
                BSI_IDX_REVISION: begin
                    hit = 1'b1;
                    if (cur.wr_strb[0] && cur.rev_unlock) begin
                        next_cur.revision_number = cur.wr_data[7:0]; // RULE10
                    end
                end
                BSI_IDX_CACHELINE: begin
                    hit = 1'b1;
                    if (cur.wr_strb[0]) begin
                        next_cur.cache_line_bytes = cur.wr_data[7:0]; // RULE9
                    end
                end
                BSI_IDX_LOCKCTL: begin
                    hit = 1'b1;
                    if (cur.wr_strb[0]) begin
                        next_cur.rev_unlock = cur.wr_data[BSI_LOCK_UNLK_BIT];
                    end
                end
                default: hit = 1'b0;
            endcase
            if (!(hit && wr_ok)) begin
                next_cur.bresp = BSI_RESP_SLVERR;
            end
        end

        // read: data captured on the same edge that takes the address
        if (cur.rvalid && i_s_axi_rready) begin
            next_cur.rvalid = 1'b0;
        end
        if (i_s_axi_arvalid && o_s_axi_arready) begin
            next_cur.rvalid = 1'b1;
            next_cur.rdata  = rd_ok ? rw[31:0] : 32'h0000_0000;
            next_cur.rresp  = (rd_ok && rw[32]) ? BSI_RESP_OKAY : BSI_RESP_SLVERR;
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cur                 <= '0;
            cur.revision_number <= BSI_REV_RESET;
            cur.cache_line_bytes <= BSI_LINE_RESET; // RULE9
        end else begin
            cur <= next_cur;
        end
    end

    // ==========================================================
    // outputs; a channel stays closed while its response is pending
    assign o_s_axi_awready      = !cur.aw_got && !cur.bvalid;
    assign o_s_axi_wready       = !cur.w_got && !cur.bvalid;
    assign o_s_axi_bvalid       = cur.bvalid;
    assign o_s_axi_bresp        = cur.bresp;
    assign o_s_axi_arready      = !cur.rvalid;
    assign o_s_axi_rvalid       = cur.rvalid;
    assign o_s_axi_rdata        = cur.rdata;
    assign o_s_axi_rresp        = cur.rresp;
    assign o_err_report_en      = cur.error_report_enable;  // reporting logic gates on this
    assign o_parity_response_en = cur.parity_response_enable;

    // ==========================================================
    // checks
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    property p_intx_follow;
        (i_hotplug_irq && !i_is_upstream) |=> cur.intx_pending_flag;
    endproperty
    a_intx_follow: assert property (p_intx_follow) else $error("intx flag missed hot-plug interrupt"); // RULE1

    property p_intx_up;
        i_is_upstream |=> !cur.intx_pending_flag;
    endproperty
    a_intx_up: assert property (p_intx_up) else $error("intx flag set in upstream port"); // RULE2

    property p_intx_fwd;
        (i_intx_fwd && !i_hotplug_irq) |=> !cur.intx_pending_flag;
    endproperty
    a_intx_fwd: assert property (p_intx_fwd) else $error("forwarded interrupt reached intx flag"); // RULE3

    property p_cap;
        (i_s_axi_arvalid && o_s_axi_arready && rd_ok && rd_idx == BSI_IDX_STATUS)
            |=> o_s_axi_rvalid && o_s_axi_rdata[BSI_ST_CAP_BIT];
    endproperty
    a_cap: assert property (p_cap) else $error("capability bit not one"); // RULE4

    property p_syserr;
        (i_err_msg_sent && cur.error_report_enable) |=> cur.system_error_signalled [*2]
            or (cur.system_error_signalled ##1 1'b1);
    endproperty
    a_syserr: assert property (p_syserr) else $error("system error flag not set"); // RULE5

    property p_syserr_gate;
        (!(i_err_msg_sent && cur.error_report_enable) && !cur.system_error_signalled) |=> !cur.system_error_signalled;
    endproperty
    a_syserr_gate: assert property (p_syserr_gate) else $error("system error flag set without cause"); // RULE11

    property p_poison;
        i_poisoned_rx |=> cur.poisoned_rx_flag;
    endproperty
    a_poison: assert property (p_poison) else $error("poisoned flag not set"); // RULE6

    property p_no_tabort;
        (i_s_axi_arvalid && o_s_axi_arready && rd_ok && rd_idx == BSI_IDX_STATUS)
            |=> !o_s_axi_rdata[BSI_ST_TABORT_BIT];
    endproperty
    a_no_tabort: assert property (p_no_tabort) else $error("target abort bit read one"); // RULE7

    property p_rsvd;
        (i_s_axi_arvalid && o_s_axi_arready && rd_ok && rd_idx == BSI_IDX_STATUS)
            |=> ((o_s_axi_rdata[15:0] & BSI_ST_FIXED_MASK) == 16'h0000) && (o_s_axi_rdata[31:16] == 16'h0000);
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved status bit read one"); // RULE12

    property p_class;
        (i_s_axi_arvalid && o_s_axi_arready && rd_ok && rd_idx == BSI_IDX_CLASS)
            |=> o_s_axi_rdata == 32'h0006_0400;
    endproperty
    a_class: assert property (p_class) else $error("class code wrong"); // RULE8

    property p_line_write;
        (wr_commit && wr_ok && wr_idx == BSI_IDX_CACHELINE && cur.wr_strb[0])
            |=> cur.cache_line_bytes == $past(cur.wr_data[7:0]);
    endproperty
    a_line_write: assert property (p_line_write) else $error("cache line size not stored"); // RULE9

    property p_rev_lock;
        (!cur.rev_unlock && !(wr_commit && wr_idx == BSI_IDX_LOCKCTL)) |=> $stable(cur.revision_number);
    endproperty
    a_rev_lock: assert property (p_rev_lock) else $error("locked revision changed"); // RULE10

endmodule

/* sim/bsi_host_model.sv */
`timescale 1ns/1ps
// ==========================================================
// host side: axi4-lite master issuing configuration requests
module bsi_host_model (
    input  wire logic        i_clk_sys,
    output logic             o_awvalid,
    input  wire logic        i_awready,
    output logic [31:0]      o_awaddr,
    output logic             o_wvalid,
    input  wire logic        i_wready,
    output logic [31:0]      o_wdata,
    output logic [3:0]       o_wstrb,
    input  wire logic        i_bvalid,
    output logic             o_bready,
    input  wire logic [1:0]  i_bresp,
    output logic             o_arvalid,
    input  wire logic        i_arready,
    output logic [31:0]      o_araddr,
    input  wire logic        i_rvalid,
    output logic             o_rready,
    input  wire logic [31:0] i_rdata,
    input  wire logic [1:0]  i_rresp
);
    // idle bus at time zero
    initial begin
        {o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready} = 5'h0;
        {o_awaddr, o_wdata, o_araddr} = 96'h0;
        o_wstrb = 4'hf;
    end

    // handshakes are judged at the falling edge, where ready has settled
    task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r, output bit ok);
        bit ta;
        bit tw;
        bit tb;
        ok = 0;
        r = 2'h3;
        @(posedge i_clk_sys);
        o_awvalid <= 1'b1;
        o_awaddr  <= a;
        o_wvalid  <= 1'b1;
        o_wdata   <= d;
        o_bready  <= 1'b1;
        for (int n = 0; n < 40 && !ok; n++) begin
            @(negedge i_clk_sys);
            ta = o_awvalid && i_awready;
            tw = o_wvalid && i_wready;
            tb = i_bvalid;
            r  = i_bresp;
            @(posedge i_clk_sys);
            // released payload flips so a stale value cannot pass
            if (ta) begin
                o_awvalid <= 1'b0;
                o_awaddr  <= ~a;
            end
            if (tw) begin
                o_wvalid <= 1'b0;
                o_wdata  <= ~d;
            end
            if (tb) begin
                o_bready <= 1'b0;
                ok = 1;
            end
        end
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r, output bit ok);
        bit ta;
        bit tr;
        ok = 0;
        @(posedge i_clk_sys);
        o_arvalid <= 1'b1;
        o_araddr  <= a;
        o_rready  <= 1'b1;
        for (int n = 0; n < 40 && !ok; n++) begin
            @(negedge i_clk_sys);
            ta = o_arvalid && i_arready;
            tr = i_rvalid;
            d  = i_rdata;
            r  = i_rresp;
            @(posedge i_clk_sys);
            if (ta) begin
                o_arvalid <= 1'b0;
                o_araddr  <= ~a;
            end
            if (tr) begin
                o_rready <= 1'b0;
                ok = 1;
            end
        end
    endtask
endmodule

/* sim/bsi_regs_tb.sv */
`timescale 1ns/1ps
module bsi_regs_tb;
    import bsi_pkg::*;
    // ==========================================================
    // nets and model state
    logic        i_clk_sys = 0;
    logic        i_rst_n = 0;
    logic        i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid, i_s_axi_rready;
    logic        o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
    logic [31:0] i_s_axi_awaddr, i_s_axi_wdata, i_s_axi_araddr, o_s_axi_rdata;
    logic [3:0]  i_s_axi_wstrb;
    logic [1:0]  o_s_axi_bresp, o_s_axi_rresp;
    logic        i_is_upstream, i_hotplug_irq, i_intx_fwd, i_err_msg_sent, i_poisoned_rx;
    logic        o_err_report_en, o_parity_response_en;
    int          fails = 0;
    int          checks = 0;
    int          m_intx = 0, m_sys = 0, m_poi = 0, m_line = 0, m_rev = BSI_REV_RESET;
    logic [31:0] seed = 32'h0000_004e;
    localparam logic [31:0] A_CMD = {18'h0, BSI_IDX_COMMAND, 2'b00};
    localparam logic [31:0] A_ST  = {18'h0, BSI_IDX_STATUS, 2'b00};
    localparam logic [31:0] A_REV = {18'h0, BSI_IDX_REVISION, 2'b00};
    localparam logic [31:0] A_CC  = {18'h0, BSI_IDX_CLASS, 2'b00};
    localparam logic [31:0] A_CL  = {18'h0, BSI_IDX_CACHELINE, 2'b00};
    localparam logic [31:0] A_LK  = {18'h0, BSI_IDX_LOCKCTL, 2'b00};

    always #25 i_clk_sys = ~i_clk_sys;

    bsi_regs i_dut (.i_clk_sys, .i_rst_n, .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_awaddr,
        .i_s_axi_wvalid, .o_s_axi_wready, .i_s_axi_wdata, .i_s_axi_wstrb, .o_s_axi_bvalid,
        .i_s_axi_bready, .o_s_axi_bresp, .i_s_axi_arvalid, .o_s_axi_arready, .i_s_axi_araddr,
        .o_s_axi_rvalid, .i_s_axi_rready, .o_s_axi_rdata, .o_s_axi_rresp, .i_is_upstream,
        .i_hotplug_irq, .i_intx_fwd, .i_err_msg_sent, .i_poisoned_rx, .o_err_report_en,
        .o_parity_response_en);

    bsi_host_model i_host (.i_clk_sys, .o_awvalid(i_s_axi_awvalid), .i_awready(o_s_axi_awready),
        .o_awaddr(i_s_axi_awaddr), .o_wvalid(i_s_axi_wvalid), .i_wready(o_s_axi_wready),
        .o_wdata(i_s_axi_wdata), .o_wstrb(i_s_axi_wstrb), .i_bvalid(o_s_axi_bvalid),
        .o_bready(i_s_axi_bready), .i_bresp(o_s_axi_bresp), .o_arvalid(i_s_axi_arvalid),
        .i_arready(o_s_axi_arready), .o_araddr(i_s_axi_araddr), .i_rvalid(o_s_axi_rvalid),
        .o_rready(i_s_axi_rready), .i_rdata(o_s_axi_rdata), .i_rresp(o_s_axi_rresp));

    // ==========================================================
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // expected status word from the model flags; capability bit always one
    function automatic logic [31:0] st();
        return 32'(m_intx * 8 + 16 + m_sys * 16384 + m_poi * 32768);
    endfunction

    task automatic conclude();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wrc(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] r;
        bit ok;
        i_host.wr(a, d, r, ok);
        if (!ok) begin
            $display("mismatch write handshake expected 1 seen 0");
            fails++;
            conclude();
        end
        chk("write response", {30'h0, er}, {30'h0, r});
    endtask

    task automatic rdc(input string what, input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        bit ok;
        i_host.rd(a, d, r, ok);
        if (!ok) begin
            $display("mismatch read handshake expected 1 seen 0");
            fails++;
            conclude();
        end
        chk(what, exp, d);
        chk("read response", {30'h0, er}, {30'h0, r});
    endtask

    // one-cycle event pulse; 0 = error message sent, 1 = poisoned arrival
    task automatic pulse(input int which);
        @(posedge i_clk_sys);
        if (which == 0) i_err_msg_sent <= 1'b1;
        else i_poisoned_rx <= 1'b1;
        @(posedge i_clk_sys);
        i_err_msg_sent <= 1'b0;
        i_poisoned_rx  <= 1'b0;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        {i_is_upstream, i_hotplug_irq, i_intx_fwd, i_err_msg_sent, i_poisoned_rx} <= 5'h0;
        repeat (8) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        rdc("status", A_ST, st(), BSI_RESP_OKAY);
        rdc("revision", A_REV, 32'(m_rev), BSI_RESP_OKAY);
        rdc("class", A_CC, 32'h0006_0400, BSI_RESP_OKAY);
        rdc("cache line", A_CL, 32'(m_line), BSI_RESP_OKAY);
        $display("test reset values done");
        // random writes: only the low byte sticks
        for (int k = 0; k < 4; k++) begin
            seed = xs(seed);
            wrc(A_CL, seed, BSI_RESP_OKAY);
            m_line = int'(seed[7:0]);
            rdc("cache line", A_CL, 32'(m_line), BSI_RESP_OKAY);
        end
        wrc(A_CC, 32'hffff_ffff, BSI_RESP_OKAY);
        rdc("class", A_CC, 32'h0006_0400, BSI_RESP_OKAY);
        wrc(A_ST, 32'hffff_ffff, BSI_RESP_OKAY);
        rdc("status", A_ST, st(), BSI_RESP_OKAY);
        $display("test read-only and cache line done");
        // port kind, hot-plug level and random forwarded interrupts
        for (int k = 0; k < 8; k++) begin
            seed = xs(seed);
            i_is_upstream <= k[1];
            i_hotplug_irq <= k[0];
            i_intx_fwd    <= seed[0];
            m_intx = int'(k[0] && !k[1]);
            rdc("status intx", A_ST, st(), BSI_RESP_OKAY);
        end
        i_hotplug_irq <= 1'b0;
        i_intx_fwd    <= 1'b1;
        m_intx = 0;
        $display("test interrupt status done");
        pulse(0);
        rdc("status gated", A_ST, st(), BSI_RESP_OKAY);
        wrc(A_CMD, 32'h0000_0140, BSI_RESP_OKAY);
        chk("error enable", 32'h1, {31'h0, o_err_report_en});
        chk("parity enable", 32'h1, {31'h0, o_parity_response_en});
        rdc("command", A_CMD, 32'h0000_0140, BSI_RESP_OKAY);
        pulse(0);
        m_sys = 1;
        rdc("status syserr", A_ST, st(), BSI_RESP_OKAY);
        wrc(A_ST, 32'h0000_0000, BSI_RESP_OKAY);
        rdc("status keep", A_ST, st(), BSI_RESP_OKAY);
        pulse(1);
        m_poi = 1;
        rdc("status poison", A_ST, st(), BSI_RESP_OKAY);
        wrc(A_ST, 32'h0000_4000, BSI_RESP_OKAY);
        m_sys = 0;
        rdc("status clear", A_ST, st(), BSI_RESP_OKAY);
        wrc(A_ST, 32'h0000_8000, BSI_RESP_OKAY);
        m_poi = 0;
        rdc("status clear", A_ST, st(), BSI_RESP_OKAY);
        $display("test error flags done");
        wrc(A_REV, 32'h0000_005a, BSI_RESP_OKAY);
        rdc("revision locked", A_REV, 32'(m_rev), BSI_RESP_OKAY);
        wrc(A_LK, 32'h0000_0001, BSI_RESP_OKAY);
        rdc("lock", A_LK, 32'h0000_0001, BSI_RESP_OKAY);
        wrc(A_REV, 32'h0000_005a, BSI_RESP_OKAY);
        m_rev = 'h5a;
        rdc("revision open", A_REV, 32'(m_rev), BSI_RESP_OKAY);
        wrc(32'h0010_0000, 32'h0000_00ff, BSI_RESP_SLVERR);
        rdc("unmapped", 32'h0010_0000, 32'h0, BSI_RESP_SLVERR);
        $display("test revision and unmapped done");
        // mid-run reset with a flag raised: error enable, status, revision and cache line must fall back to their defaults
        pulse(1);
        @(posedge i_clk_sys);
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        m_poi = 0;
        m_line = 0;
        m_rev = BSI_REV_RESET;
        chk("error enable reset", 32'h0, {31'h0, o_err_report_en});
        rdc("status reset", A_ST, st(), BSI_RESP_OKAY);
        rdc("revision reset", A_REV, 32'(m_rev), BSI_RESP_OKAY);
        rdc("cache line reset", A_CL, 32'(m_line), BSI_RESP_OKAY);
        $display("test mid-run reset done");
        conclude();
    end
endmodule
